//--- core/access_if.sv
// Carrier between the access sequencer and the pin state decoder
`timescale 1ns/1ps
`default_nettype none
`include "strobe_encoder_defines.svh"
interface access_if;
   import strobe_encoder_pkg::*;

   // Access context
   state_t              state;
   logic                is_dram;
   logic                is_16;
   logic                up;
   logic                lo;
   logic                write;
   logic [2:0]          area;
   logic                two_cas;
   logic                bsel_sys;
   logic                par_dram;
   logic                par_area2;
   logic [`ADDR_W-1:0]  addr;
   logic [`DATA_W-1:0]  wdata;

   // Next pin levels
   logic [`CS_W-1:0]    cs_n;
   logic                ras_n;
   logic                ucas_n;
   logic                lcas_n;
   logic                hold;
   logic                rd_n;
   logic                uws_n;
   logic                lws_n;
   logic [`ADDR_W-1:0]  a;
   logic [`DATA_W-1:0]  d_o;
   logic [1:0]          d_oe;
   logic [1:0]          p_o;
   logic [1:0]          p_oe;

   modport ctrl (
      output state, is_dram, is_16, up, lo, write, area, two_cas,
      output bsel_sys, par_dram, par_area2, addr, wdata,
      input  cs_n, ras_n, ucas_n, lcas_n, hold, rd_n, uws_n, lws_n,
      input  a, d_o, d_oe, p_o, p_oe
   );
   modport dec (
      input  state, is_dram, is_16, up, lo, write, area, two_cas,
      input  bsel_sys, par_dram, par_area2, addr, wdata,
      output cs_n, ras_n, ucas_n, lcas_n, hold, rd_n, uws_n, lws_n,
      output a, d_o, d_oe, p_o, p_oe
   );
endinterface
`default_nettype wire

//--- core/external_bus_strobe_encoder.sv
// Sequencer and pin registers for DRAM and external memory accesses
`timescale 1ns/1ps
`default_nettype none
`include "strobe_encoder_defines.svh"

module external_bus_strobe_encoder
   import strobe_encoder_pkg::*;
(
   // Clock and reset
   input  wire logic                sys_clk_in,
   input  wire logic                resetn_in,
   // Access request
   input  wire logic                req_valid_in,
   output logic                     req_ready_out,
   input  wire logic                req_dram_in,
   input  wire logic                req_16bit_in,
   input  wire logic [1:0]          req_lane_in,
   input  wire logic                req_write_in,
   input  wire logic [2:0]          req_area_in,
   input  wire logic [`ADDR_W-1:0]  req_addr_in,
   input  wire logic [`DATA_W-1:0]  req_wdata_in,
   // Configuration
   input  wire logic                dram_two_cas_in,
   input  wire logic                ext_byte_select_sys_in,
   input  wire logic                parity_enable_hi_in,
   input  wire logic                parity_enable_lo_in,
   // Access answer
   output logic                     done_out,
   output logic [`DATA_W-1:0]       rdata_out,
   output logic                     parity_err_out,
   // Bus pins
   output logic [`CS_W-1:0]         cs_n_out,
   output logic                     ras_n_out,
   output logic                     upper_column_strobe_n_out,
   output logic                     lower_column_strobe_n_out,
   output logic                     address_hold_out,
   output logic                     rd_n_out,
   output logic                     upper_write_strobe_n_out,
   output logic                     lower_write_strobe_n_out,
   output logic [`ADDR_W-1:0]       addr_out,
   output logic [`DATA_W-1:0]       data_out,
   output logic [1:0]               data_oe_out,
   input  wire logic [`DATA_W-1:0]  data_in,
   output logic [1:0]               parity_out,
   output logic [1:0]               parity_oe_out,
   input  wire logic [1:0]          parity_in
);

   state_t              state_r;
   logic [1:0]          tail_cnt_r;
   logic                is_dram_r;
   logic                is_16_r;
   logic                up_r;
   logic                lo_r;
   logic                write_r;
   logic [2:0]          area_r;
   logic                two_cas_r;
   logic                bsel_sys_r;
   logic [1:0]          par_mode_r;
   logic [`ADDR_W-1:0]  addr_r;
   logic [`DATA_W-1:0]  wdata_r;
   logic [17:0]         pin_s1_r;
   logic [17:0]         pin_s2_r;
   logic                take;
   logic                par_chk;
   logic [1:0]          rd_err;

   access_if acc_bus ();

   pin_state_decoder u_dec (
      .bus (acc_bus.dec)
   );

   ////////////////////////////////////////////////////////////////////////
   // Context toward the decoder
   assign acc_bus.state     = state_r;
   assign acc_bus.is_dram   = is_dram_r;
   assign acc_bus.is_16     = is_16_r;
   assign acc_bus.up        = up_r;
   assign acc_bus.lo        = lo_r;
   assign acc_bus.write     = write_r;
   assign acc_bus.area      = area_r;
   assign acc_bus.two_cas   = two_cas_r;
   assign acc_bus.bsel_sys  = bsel_sys_r;
   assign acc_bus.par_dram  = (par_mode_r == `PAR_DRAM);
   assign acc_bus.par_area2 = (par_mode_r == `PAR_AREA2);
   assign acc_bus.addr      = addr_r;
   assign acc_bus.wdata     = wdata_r;

   assign take = req_valid_in && req_ready_out;

   ////////////////////////////////////////////////////////////////////////
   // Latch the request; 8-bit space always uses the low lane only
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         is_dram_r  <= 1'b0;
         is_16_r    <= 1'b0;
         up_r       <= 1'b0;
         lo_r       <= 1'b0;
         write_r    <= 1'b0;
         area_r     <= 3'h0;
         two_cas_r  <= 1'b0;
         bsel_sys_r <= 1'b0;
         par_mode_r <= `PAR_OFF;
         addr_r     <= '0;
         wdata_r    <= '0;
      end else if (take) begin
         is_dram_r  <= req_dram_in;
         is_16_r    <= req_16bit_in;
         up_r       <= req_16bit_in && (req_lane_in != LANE_LOWER);
         lo_r       <= !req_16bit_in || (req_lane_in != LANE_UPPER);
         write_r    <= req_write_in;
         area_r     <= req_area_in;
         two_cas_r  <= dram_two_cas_in;
         bsel_sys_r <= ext_byte_select_sys_in;
         par_mode_r <= {parity_enable_hi_in, parity_enable_lo_in};
         addr_r     <= req_addr_in;
         wdata_r    <= req_wdata_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Access sequencer; the tail holds strobes while read data syncs
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_r    <= ST_IDLE;
         tail_cnt_r <= 2'h0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (take) begin
                  state_r <= req_dram_in ? ST_ROW : ST_EXT;
               end
            end
            ST_ROW: begin
               state_r <= ST_COL;
            end
            ST_COL, ST_EXT: begin
               state_r    <= ST_TAIL;
               tail_cnt_r <= 2'h0;
            end
            ST_TAIL: begin
               if (tail_cnt_r == `TAIL_LAST) begin
                  state_r <= ST_IDLE;
               end
               tail_cnt_r <= tail_cnt_r + 2'h1;
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin inputs pass two flops; stage one feeds only stage two
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pin_s1_r <= '0;
         pin_s2_r <= '0;
      end else begin
         pin_s1_r <= {parity_in, data_in};
         pin_s2_r <= pin_s1_r;
      end
   end

   // Parity check on the lanes of a read, when enabled for the space
   assign par_chk = is_dram_r ? acc_bus.par_dram
                    : (acc_bus.par_area2 && area_r == `PARITY_AREA);
   assign rd_err  = {pin_s2_r[17] != ~^pin_s2_r[15:8],
                     pin_s2_r[16] != ~^pin_s2_r[7:0]};

   ////////////////////////////////////////////////////////////////////////
   // Answer: ready, done pulse, read data and parity error
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         req_ready_out  <= 1'b0;
         done_out       <= 1'b0;
         rdata_out      <= '0;
         parity_err_out <= 1'b0;
      end else begin
         done_out <= 1'b0;
         if (take) begin
            req_ready_out <= 1'b0;
         end else if (state_r == ST_IDLE) begin
            req_ready_out <= 1'b1;
         end
         if (state_r == ST_TAIL && tail_cnt_r == `TAIL_LAST) begin
            done_out <= 1'b1;
            if (!write_r) begin
               rdata_out <= pin_s2_r[15:0]
                            & {{8{up_r}}, {8{lo_r}}};
               parity_err_out <= par_chk
                  && ((rd_err[1] && up_r) || (rd_err[0] && lo_r));
            end else begin
               parity_err_out <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin registers; every pin comes straight from a flop
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cs_n_out                  <= '1;
         ras_n_out                 <= 1'b1;
         upper_column_strobe_n_out <= 1'b1;
         lower_column_strobe_n_out <= 1'b1;
         address_hold_out          <= 1'b0;
         rd_n_out                  <= 1'b1;
         upper_write_strobe_n_out  <= 1'b1;
         lower_write_strobe_n_out  <= 1'b1;
         addr_out                  <= '0;
         data_out                  <= '0;
         data_oe_out               <= 2'h0;
         parity_out                <= 2'h0;
         parity_oe_out             <= 2'h0;
      end else begin
         cs_n_out                  <= acc_bus.cs_n;
         ras_n_out                 <= acc_bus.ras_n;
         upper_column_strobe_n_out <= acc_bus.ucas_n;
         lower_column_strobe_n_out <= acc_bus.lcas_n;
         address_hold_out          <= acc_bus.hold;
         rd_n_out                  <= acc_bus.rd_n;
         upper_write_strobe_n_out  <= acc_bus.uws_n;
         lower_write_strobe_n_out  <= acc_bus.lws_n;
         addr_out                  <= acc_bus.a;
         data_out                  <= acc_bus.d_o;
         data_oe_out               <= acc_bus.d_oe;
         parity_out                <= acc_bus.p_o;
         parity_oe_out             <= acc_bus.p_oe;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks on the pin sequence
   logic [`CS_W-1:0] cs_expect;
   assign cs_expect = ~(`CS_W'(1) << area_r);

   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!resetn_in);

   a_row_strobe_addr: assert property (
      (state_r == ST_ROW) |=> (!ras_n_out
         && addr_out == (addr_r >> `COL_BITS)) ##1 (!ras_n_out
         && addr_out == (addr_r & `ADDR_W'((1 << `COL_BITS) - 1))))
      else $error("row then column address not framed by row strobe");

   a_upper_cas: assert property (
      (state_r == ST_COL && is_dram_r && is_16_r && two_cas_r && up_r)
      |=> (!upper_column_strobe_n_out && !cs_n_out[`DRAM_CS_IDX])[*4])
      else $error("upper column strobe missing in column phase");

   a_lower_cas: assert property (
      (state_r == ST_COL && is_dram_r && lo_r)
      |=> !lower_column_strobe_n_out && !ras_n_out)
      else $error("lower column strobe missing in column phase");

   a_dram_parity: assert property (
      (state_r == ST_COL && is_dram_r && write_r && lo_r
       && par_mode_r == `PAR_DRAM)
      |=> parity_oe_out[0] && parity_out[0] == ~^wdata_r[7:0])
      else $error("DRAM parity lane not driven");

   a_area2_parity: assert property (
      (state_r == ST_EXT && write_r && area_r == `PARITY_AREA
       && par_mode_r == `PAR_AREA2)
      |=> parity_oe_out == {up_r && is_16_r, lo_r})
      else $error("area parity lanes wrong");

   a_one_select: assert property (
      (state_r == ST_EXT) |=> (cs_n_out == cs_expect) [*4])
      else $error("chip select pattern wrong in external access");

   a_ext_idle_strobes: assert property (
      (state_r == ST_EXT) |=> ras_n_out && upper_column_strobe_n_out
         && lower_column_strobe_n_out && !address_hold_out
         && rd_n_out == write_r)
      else $error("DRAM strobes or read strobe wrong in external access");

   a_narrow_lanes: assert property (
      (state_r == ST_EXT && !is_16_r && write_r)
      |=> data_oe_out == 2'h1 && data_out[7:0] == wdata_r[7:0]
         ##4 data_oe_out == 2'h0)
      else $error("8-bit lanes wrong or not released");

endmodule
`default_nettype wire

//--- core/pin_state_decoder.sv
// Pin level decoder for DRAM and external memory space accesses
`timescale 1ns/1ps
`default_nettype none
`include "strobe_encoder_defines.svh"
module pin_state_decoder
   import strobe_encoder_pkg::*;
(
   access_if.dec bus
);

   logic active;
   logic col_ph;
   logic par_en;

   assign active = (bus.state != ST_IDLE);
   assign col_ph = (bus.state == ST_COL) || (bus.state == ST_TAIL)
                   || (bus.state == ST_EXT);
   assign par_en = bus.is_dram ? bus.par_dram
                   : (bus.par_area2 && bus.area == `PARITY_AREA);

   ////////////////////////////////////////////////////////////////////////
   // Strobe, select and lane levels; idle levels are the defaults
   always_comb begin
      bus.cs_n   = '1;
      bus.ras_n  = 1'b1;
      bus.ucas_n = 1'b1;
      bus.lcas_n = 1'b1;
      bus.hold   = 1'b0;
      bus.rd_n   = 1'b1;
      bus.uws_n  = 1'b1;
      bus.lws_n  = 1'b1;
      bus.a      = bus.addr;
      bus.d_o    = bus.wdata;
      bus.d_oe   = 2'h0;
      bus.p_o    = {~^bus.wdata[15:8], ~^bus.wdata[7:0]};
      bus.p_oe   = 2'h0;
      if (active && bus.is_dram) begin
         bus.ras_n = 1'b0;
         bus.rd_n  = bus.write;
         // Row first, then column with the upper bits cleared
         if (bus.state == ST_ROW) begin
            bus.a = bus.addr >> `COL_BITS;
         end else begin
            bus.a = bus.addr & `ADDR_W'((1 << `COL_BITS) - 1);
         end
         if (!(bus.is_16 && bus.two_cas)) begin
            bus.cs_n[`DRAM_CS_IDX] = 1'b0;
         end
         if (col_ph) begin
            if (bus.is_16 && bus.two_cas) begin
               bus.ucas_n = !bus.up;
               bus.lcas_n = !bus.lo;
               // Select pin doubles as the upper column strobe
               bus.cs_n[`DRAM_CS_IDX] = !bus.up;
               bus.lws_n  = !bus.write;
            end else if (bus.is_16) begin
               bus.lcas_n = 1'b0;
               bus.uws_n  = !(bus.write && bus.up);
               bus.lws_n  = !(bus.write && bus.lo);
            end else begin
               bus.lcas_n = 1'b0;
               bus.lws_n  = !bus.write;
            end
         end
      end else if (active) begin
         bus.cs_n[bus.area] = 1'b0;
         bus.rd_n = bus.write;
         if (!bus.is_16) begin
            bus.lws_n = !bus.write;
         end else if (bus.bsel_sys) begin
            bus.uws_n = !bus.lo;
            bus.lws_n = !bus.write;
            bus.a[0]  = !bus.up;
         end else begin
            bus.uws_n = !(bus.write && bus.up);
            bus.lws_n = !(bus.write && bus.lo);
         end
      end
      // Only written lanes drive; the rest float
      if (active && col_ph && bus.write) begin
         bus.d_oe = {bus.up && bus.is_16, bus.lo};
         bus.p_oe = par_en ? {bus.up && bus.is_16, bus.lo} : 2'h0;
      end
   end

endmodule
`default_nettype wire

//--- core/strobe_encoder_defines.svh
// Constants for the external bus strobe encoder
`ifndef STROBE_ENCODER_DEFINES_SVH
`define STROBE_ENCODER_DEFINES_SVH

`define ADDR_W        22
`define DATA_W        16
`define CS_W          8
`define COL_BITS      10
`define TAIL_LAST     2'h2
`define PAR_OFF       2'h0
`define PAR_DRAM      2'h1
`define PAR_AREA2     2'h2
`define PARITY_AREA   3'h2
`define DRAM_CS_IDX   1

`endif

//--- core/strobe_encoder_pkg.sv
// Types shared by the external bus strobe encoder modules
package strobe_encoder_pkg;

   // Access phases, Gray coded along idle-row-column-tail
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ROW  = 3'h1,
      ST_COL  = 3'h3,
      ST_TAIL = 3'h2,
      ST_EXT  = 3'h6
   } state_t;

   // Byte lanes touched by a 16-bit access
   typedef enum logic [1:0] {
      LANE_UPPER = 2'h0,
      LANE_LOWER = 2'h1,
      LANE_WORD  = 2'h2
   } lane_t;

endpackage

//--- verif/ext_memory_model.sv
// Behavioural memory that answers reads on the external bus pins
`timescale 1ns/1ps
`default_nettype none
module ext_memory_model (
   // Bench clock and pins driven by the device
   input  wire logic        clk_in,
   input  wire logic [7:0]  cs_n_in,
   input  wire logic        ras_n_in,
   input  wire logic        uc_n_in,
   input  wire logic        lc_n_in,
   input  wire logic        rd_n_in,
   input  wire logic [21:0] addr_in,
   input  wire logic [15:0] dev_data_in,
   input  wire logic [1:0]  dev_oe_in,
   input  wire logic [1:0]  dev_par_in,
   input  wire logic [1:0]  dev_par_oe_in,
   // Fault control from the bench
   input  wire logic        bad_par_in,
   // Resolved wire levels
   output logic [15:0]      data_out,
   output logic [1:0]       par_out
);
   logic [11:0] row_r = 12'h000;
   logic [15:0] last_r = 16'h0000;
   logic        hit;
   logic [14:0] top;
   logic [15:0] val;
   logic [1:0]  par;
   // Row half is caught before any column strobe falls
   always_ff @(posedge clk_in) begin
      if (!ras_n_in && uc_n_in && lc_n_in)
         row_r <= addr_in[11:0];
      if (hit)
         last_r <= val;
   end
   // Without pulls a released line shows the inverse, never the old value
   assign hit = !rd_n_in && (ras_n_in ? (cs_n_in != 8'hFF)
                                      : !(uc_n_in && lc_n_in));
   assign top = ras_n_in ? addr_in[15:1] : {row_r[5:0], addr_in[9:1]};
   assign val = hit ? ({top, 1'h0} ^ 16'hA5C3) : ~last_r;
   // Odd parity per byte, spoiled on request
   assign par = {~^val[15:8], ~^val[7:0]} ^ {2{bad_par_in | !hit}};
   // A lane the device drives carries the device's level
   assign data_out = {dev_oe_in[1] ? dev_data_in[15:8] : val[15:8],
                      dev_oe_in[0] ? dev_data_in[7:0] : val[7:0]};
   assign par_out = (dev_par_oe_in & dev_par_in) | (~dev_par_oe_in & par);
endmodule
`default_nettype wire

//--- verif/external_bus_strobe_encoder_test.sv
// Self-checking bench for the external bus strobe encoder
`timescale 1ns/1ps
`default_nettype none
module external_bus_strobe_encoder_test;
   logic        clk = 1'h0, rst_n = 1'h0, vld = 1'h0, dram = 1'h0;
   logic        b16 = 1'h0, wr = 1'h0, two_cas = 1'h0, bsel = 1'h0;
   logic        phi = 1'h0, plo = 1'h0, bad = 1'h0;
   logic [1:0]  lane = 2'h0;
   logic [2:0]  area = 3'h0;
   logic [21:0] addr = 22'h0;
   logic [15:0] wd = 16'h0;
   logic        rdy, done, perr, ras_n, uc_n, lc_n, hold, rd_n, uw_n, lw_n;
   logic [7:0]  cs_n, fl, cs_and;
   logic [21:0] a, row_a, col_a, x_a;
   logic [15:0] rdat, dout, din, d_seen;
   logic [1:0]  oe, pout, poe, pin, oe_or, poe_or, p_seen;
   int          n_mismatch = 0, n_tests = 0, lat;

   external_bus_strobe_encoder i_external_bus_strobe_encoder (
      .sys_clk_in(clk), .resetn_in(rst_n), .req_valid_in(vld),
      .req_ready_out(rdy), .req_dram_in(dram), .req_16bit_in(b16),
      .req_lane_in(lane), .req_write_in(wr), .req_area_in(area),
      .req_addr_in(addr), .req_wdata_in(wd), .dram_two_cas_in(two_cas),
      .ext_byte_select_sys_in(bsel), .parity_enable_hi_in(phi),
      .parity_enable_lo_in(plo), .done_out(done), .rdata_out(rdat),
      .parity_err_out(perr), .cs_n_out(cs_n), .ras_n_out(ras_n),
      .upper_column_strobe_n_out(uc_n), .lower_column_strobe_n_out(lc_n),
      .address_hold_out(hold), .rd_n_out(rd_n),
      .upper_write_strobe_n_out(uw_n), .lower_write_strobe_n_out(lw_n),
      .addr_out(a), .data_out(dout), .data_oe_out(oe), .data_in(din),
      .parity_out(pout), .parity_oe_out(poe), .parity_in(pin));
   ext_memory_model i_ext_memory_model (
      .clk_in(clk), .cs_n_in(cs_n), .ras_n_in(ras_n), .uc_n_in(uc_n),
      .lc_n_in(lc_n), .rd_n_in(rd_n), .addr_in(a), .dev_data_in(dout),
      .dev_oe_in(oe), .dev_par_in(pout), .dev_par_oe_in(poe),
      .bad_par_in(bad), .data_out(din), .par_out(pin));

   // Clock at 40 MHz
   always #12.5 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic give_up(input string m);
      n_mismatch++;
      $display("[FAIL] %0t %s", $time, m);
      summarize();
   endtask
   task automatic chk(input logic [21:0] got, exp, input string m);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   // Word the memory model returns for an address
   function automatic logic [15:0] mem(input logic [21:0] x);
      return {x[15:1], 1'h0} ^ 16'hA5C3;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // One access: held until taken, then pins gathered until done
   task automatic access(input logic [21:0] ad, input logic [15:0] w);
      int n;
      @(negedge clk);
      addr = ad;
      wd = w;
      vld = 1'h1;
      for (n = 0; rdy !== 1'h1; n++) begin
         if (n > 40)
            give_up("ready never rose");
         @(negedge clk);
      end
      @(posedge clk);
      @(negedge clk);
      vld = 1'h0;
      fl = 8'h00;
      cs_and = 8'hFF;
      row_a = 22'h3FFFFF;
      col_a = 22'h3FFFFF;
      x_a = 22'h3FFFFF;
      oe_or = 2'h0;
      poe_or = 2'h0;
      for (lat = 0; done !== 1'h1; lat++) begin
         if (lat > 20)
            give_up("done never came");
         fl |= {rdy, hold, ~ras_n, ~uc_n, ~lc_n, ~rd_n, ~uw_n, ~lw_n};
         cs_and &= cs_n;
         if (!ras_n && uc_n && lc_n)
            row_a = a;
         if (!uc_n || !lc_n)
            col_a = a;
         // External space: address with its byte select bit
         if (ras_n && cs_n != 8'hFF)
            x_a = a;
         if (oe != 2'h0)
            d_seen = dout;
         if (poe != 2'h0)
            p_seen = pout;
         oe_or |= oe;
         poe_or |= poe;
         @(negedge clk);
      end
   endtask
   // Strobes ever low, selects ever low, enables and answer time
   task automatic verify(input logic [7:0] f, cs, input logic [1:0] o, po);
      chk(22'(fl), 22'(f), "strobes");
      chk(22'(cs_and), 22'(cs), "selects");
      chk(22'(oe_or), 22'(o), "data enables");
      chk(22'(poe_or), 22'(po), "parity enables");
      chk(22'(lat), dram ? 22'h5 : 22'h4, "latency");
   endtask
   // Lane contents; unread lanes of the answer must be zero
   task automatic chk_data(input logic [15:0] m, input logic pe);
      logic [1:0] pm, ep;
      pm = {m[15], m[0]};
      ep = {~^wd[15:8], ~^wd[7:0]} & pm;
      if (wr) begin
         chk(22'(d_seen & m), 22'(wd & m), "write data");
         if (pe)
            chk(22'(p_seen & pm), 22'(ep), "write parity");
      end else begin
         chk(22'(rdat), 22'(mem(addr) & m), "read data");
         chk(22'(perr), 22'h0, "parity error");
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_dram8();
      dram = 1'h1;
      for (int w = 0; w < 2; w++) begin
         wr = w[0];
         access(22'h2B5A6C, 16'hC35A);
         chk(row_a, addr >> 10, "row address");
         chk(col_a, {12'h0, addr[9:0]}, "column address");
         verify({3'h1, 1'h0, 1'h1, !wr, 1'h0, wr}, 8'hFD, {1'h0, wr}, 2'h0);
         chk_data(16'h00FF, 1'h0);
      end
      $display("dram byte test done");
   endtask
   // Parity is off (both bits set) while two column strobes are used
   task automatic t_dram16(input logic tc);
      logic uc, lc;
      dram = 1'h1;
      b16 = 1'h1;
      two_cas = tc;
      phi = tc;
      plo = 1'h1;
      bad = tc;
      for (int i = 0; i < 6; i++) begin
         lane = 2'(i / 2);
         wr = i[0];
         uc = (lane != 2'h1);
         lc = (lane != 2'h0);
         access(22'h15A3C0 + 22'(i), 16'h6A95);
         verify({3'h1, tc & uc, !tc | lc, !wr, !tc & wr & uc,
                 tc ? wr : wr & lc}, (tc & !uc) ? 8'hFF : 8'hFD,
                wr ? {uc, lc} : 2'h0, (!tc & wr) ? {uc, lc} : 2'h0);
         chk_data({{8{uc}}, {8{lc}}}, !tc);
      end
      bad = 1'h1;
      wr = 1'h0;
      access(22'h0003F0, 16'h0);
      chk(22'(perr), {21'h0, !tc}, "spoiled parity");
      bad = 1'h0;
      $display("dram word test done");
   endtask
   // Upper lane requested on purpose: an 8-bit space must ignore it
   task automatic t_ext8();
      dram = 1'h0;
      b16 = 1'h0;
      lane = 2'h0;
      phi = 1'h0;
      plo = 1'h0;
      for (int i = 0; i < 8; i++) begin
         area = 3'(i);
         wr = i[0];
         access(22'h0F0F00 + 22'(i), 16'hE718);
         verify({5'h0, !wr, 1'h0, wr}, ~(8'h01 << area), {1'h0, wr}, 2'h0);
         chk(x_a, addr, "ext address");
         chk_data(16'h00FF, 1'h0);
      end
      $display("external byte test done");
   endtask
   // Area 2 carries parity, area 3 gets spoiled parity that must be ignored
   task automatic t_ext16();
      logic uc, lc;
      dram = 1'h0;
      b16 = 1'h1;
      phi = 1'h1;
      plo = 1'h0;
      for (int i = 0; i < 24; i++) begin
         bsel = i[0];
         area = i[1] ? 3'h3 : 3'h2;
         bad = i[1];
         wr = i[2];
         lane = 2'(i / 8);
         uc = (lane != 2'h1);
         lc = (lane != 2'h0);
         access(22'h2C3E10 + 22'(i), 16'h93C6);
         verify({5'h0, !wr, bsel ? lc : wr & uc, bsel ? wr : wr & lc},
                ~(8'h01 << area), wr ? {uc, lc} : 2'h0,
                (!i[1] & wr) ? {uc, lc} : 2'h0);
         chk_data({{8{uc}}, {8{lc}}}, !i[1]);
         chk(x_a, bsel ? {addr[21:1], !uc} : addr, "ext address");
      end
      area = 3'h2;
      bad = 1'h1;
      wr = 1'h0;
      access(22'h000100, 16'h0);
      chk(22'(perr), 22'h1, "spoiled parity");
      bad = 1'h0;
      $display("external word test done");
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(negedge clk);
      chk(22'({cs_n, rdy, oe, poe, ras_n}), 22'h3FC1, "reset levels");
      rst_n = 1'h1;
      t_dram8();
      t_dram16(1'h1);
      t_dram16(1'h0);
      t_ext8();
      t_ext16();
      summarize();
   end
endmodule
`default_nettype wire
